// *** rtl/tsma_pwm.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsma_pwm import tsma_pkg::*; #(
   parameter int STEPS = DUTY_STEPS
) (
   input wire logic ref_clk,
   input wire logic resetn,
   tsma_drive_if.stage drv,
   output logic term_a_pos,
   output logic term_b_pos
);
   logic [DUTY_W-1:0] cnt;
   logic [DUTY_W-1:0] next_cnt;
   logic next_a;
   logic next_b;
   logic [DUTY_W-1:0] mag;
   logic on;
   logic heat;
   logic a_side;

   // One frame of STEPS slots; on for |duty| slots, sign picks direction
   always_comb begin
      mag = drv.duty[DUTY_W] ? DUTY_W'(-drv.duty) : drv.duty[DUTY_W-1:0];
      next_cnt = (cnt == DUTY_W'(STEPS - 1)) ? '0 : cnt + 1'b1;
      on = cnt < mag;
      heat = !drv.duty[DUTY_W] && (mag != '0);
      // Polarity swaps terminals so no rewiring is needed
      a_side = heat ^ drv.heat_polarity_b;
      next_a = on && a_side;
      next_b = on && !a_side;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= '0;
         term_a_pos <= 1'b0;
         term_b_pos <= 1'b0;
      end else begin
         cnt <= next_cnt;
         term_a_pos <= next_a;
         term_b_pos <= next_b;
      end
   end
endmodule : tsma_pwm
`default_nettype wire

// *** rtl/tsma_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsma_top import tsma_pkg::*; #(
   parameter int LED_HALF = LED_HALF_CYCLES,
   parameter int PID_TICK = PID_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire tsma_src_t setpoint_source,
   input wire tsma_reg_t regulation,
   input wire tsma_alarm_t alarm_type,
   input wire logic heat_polarity_b,
   input wire logic display_enable,
   input wire logic signed [TEMP_W-1:0] host_setpoint,
   input wire logic signed [TEMP_W-1:0] fixed_set,
   input wire logic signed [TEMP_W-1:0] range_low,
   input wire logic signed [TEMP_W-1:0] range_high,
   input wire logic [ADC_W-1:0] remote_code,
   input wire logic signed [TEMP_W-1:0] secondary_temp,
   input wire logic signed [TEMP_W-1:0] keypad_setpoint,
   input wire logic signed [TEMP_W-1:0] measured_temp,
   input wire logic [GAIN_W-1:0] gain_p,
   input wire logic [GAIN_W-1:0] gain_i,
   input wire logic [GAIN_W-1:0] gain_d,
   input wire logic signed [TEMP_W-1:0] alarm_high_set,
   input wire logic signed [TEMP_W-1:0] alarm_low_set,
   input wire logic alarm_high_en,
   input wire logic alarm_low_en,
   input wire logic [TEMP_W-1:0] alarm_hysteresis,
   input wire logic host_alarm_cmd,
   output logic signed [TEMP_W-1:0] target_temp,
   output logic signed [DUTY_W:0] duty_level,
   output logic alarm_active,
   output logic alarm_high,
   output logic alarm_low,
   output logic led_green,
   output logic term_a_pos,
   output logic term_b_pos
);
   // Saturate a wide value into [lo, hi]
   function automatic int clamp(input int v, input int lo, input int hi);
      int r;
      r = v;
      if (r > hi) begin
         r = hi;
      end
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction : clamp

   // Linear map of the full remote span onto [lo, hi]
   function automatic int scale_remote(input logic [ADC_W-1:0] code, input int lo, input int hi);
      int span;
      span = hi - lo;
      return lo + (span * int'(code)) / int'(ADC_FULL);
   endfunction : scale_remote

   tsma_drive_if drv ();

   // Set point path; remote_val also feeds the host-output duty
   logic remote_sel;
   int remote_val;
   int raw_target;
   logic signed [TEMP_W-1:0] next_target;

   // Set point selection; remote front end feeds one code for all three kinds
   always_comb begin
      remote_sel = (setpoint_source == pot_setpoint_source) ||
                   (setpoint_source == voltage_setpoint_source) ||
                   (setpoint_source == current_loop_setpoint_source);
      remote_val = scale_remote(remote_code, int'(range_low), int'(range_high));
      raw_target = int'(target_temp);
      unique case (setpoint_source)
         host_value_setpoint_source: raw_target = int'(host_setpoint);
         pot_setpoint_source,
         voltage_setpoint_source,
         current_loop_setpoint_source: raw_target = remote_val;
         differential_setpoint_source: raw_target = int'(secondary_temp) + int'(fixed_set);
         keypad_setpoint_source: begin
            // Holds the last target while the display is disabled
            if (display_enable) begin
               raw_target = int'(keypad_setpoint);
            end
         end
         default: raw_target = int'(target_temp);
      endcase
      // Range limits given by the host; keypad range is pushed separately
      next_target = TEMP_W'(clamp(raw_target, int'(range_low), int'(range_high)));
   end

   // Registered so every consumer sees one target per cycle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         target_temp <= '0;
      end else begin
         target_temp <= next_target;
      end
   end

   // Regulation state
   int tick_cnt;
   int next_tick_cnt;
   int integ;
   int next_integ;
   int prev_err;
   int next_prev_err;
   logic signed [DUTY_W:0] next_duty;
   logic heat_pol;
   logic next_heat_pol;
   int err;
   int deriv;
   int u;

   always_comb begin
      err = int'(target_temp) - int'(measured_temp);
      next_tick_cnt = (tick_cnt >= PID_TICK - 1) ? 0 : tick_cnt + 1;
      next_integ = integ;
      next_prev_err = prev_err;
      next_duty = duty_level;
      deriv = 0;
      u = 0;
      next_heat_pol = heat_polarity_b;
      unique case (regulation)
         on_off_regulation: begin
            // Full heat below target, full cool above, idle on target
            if (err > 0) begin
               next_duty = DUTY_MAX;
            end else if (err < 0) begin
               next_duty = -DUTY_MAX;
            end else begin
               next_duty = '0;
            end
            next_integ = 0;
            next_prev_err = err;
         end
         pid_regulation: begin
            // Updates at the loop tick; integral clamped against windup
            if (tick_cnt == 0) begin
               next_integ = clamp(integ + err, -INTEG_LIMIT, INTEG_LIMIT);
               deriv = err - prev_err;
               u = (int'(gain_p) * err + int'(gain_i) * next_integ + int'(gain_d) * deriv) >>> PID_SHIFT;
               next_duty = (DUTY_W + 1)'(clamp(u, -DUTY_STEPS, DUTY_STEPS));
               next_prev_err = err;
            end
         end
         host_output_regulation: begin
            // Remote input then sets the duty instead of a temperature
            if (remote_sel) begin
               next_duty = (DUTY_W + 1)'(clamp(remote_val, -DUTY_STEPS, DUTY_STEPS));
            end else begin
               next_duty = (DUTY_W + 1)'(clamp(int'(fixed_set), -DUTY_STEPS, DUTY_STEPS));
            end
            next_integ = 0;
            next_prev_err = err;
         end
         default: next_duty = '0;
      endcase
   end

   // Loop state resets to idle with zero drive
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt <= 0;
         integ <= 0;
         prev_err <= 0;
         duty_level <= '0;
         heat_pol <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         integ <= next_integ;
         prev_err <= next_prev_err;
         duty_level <= next_duty;
         heat_pol <= next_heat_pol;
      end
   end

   assign drv.duty = duty_level;
   assign drv.heat_polarity_b = heat_pol;

   // Output stage; polarity registered once so both terminals switch together
   tsma_pwm #(
      .STEPS(DUTY_STEPS)
   ) u_pwm (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .drv(drv.stage),
      .term_a_pos(term_a_pos),
      .term_b_pos(term_b_pos)
   );

   // Alarm evaluation
   int hi_thr;
   int lo_thr;
   int hyst;
   int temp_i;
   logic next_high;
   logic next_low;
   logic next_alarm;

   always_comb begin
      temp_i = int'(measured_temp);
      // Out-of-span hysteresis is pulled back into its legal range
      hyst = clamp(int'(alarm_hysteresis), HYST_MIN, HYST_MAX);
      if (alarm_type == relative_alarm_mode) begin
         hi_thr = int'(target_temp) + int'(alarm_high_set);
         lo_thr = int'(target_temp) + int'(alarm_low_set);
      end else begin
         hi_thr = int'(alarm_high_set);
         lo_thr = int'(alarm_low_set);
      end
      next_high = alarm_high;
      next_low = alarm_low;
      // Set only beyond the threshold, held at it; clear only after the full margin
      if (temp_i > hi_thr) begin
         next_high = 1'b1;
      end else if (temp_i <= hi_thr - hyst) begin
         next_high = 1'b0;
      end
      if (temp_i < lo_thr) begin
         next_low = 1'b1;
      end else if (temp_i >= lo_thr + hyst) begin
         next_low = 1'b0;
      end
      next_high = next_high && alarm_high_en;
      next_low = next_low && alarm_low_en;
      unique case (alarm_type)
         alarm_disabled, host_forced_alarm: begin
            next_high = 1'b0;
            next_low = 1'b0;
         end
         default: begin
         end
      endcase
      if (alarm_type == host_forced_alarm) begin
         next_alarm = host_alarm_cmd;
      end else begin
         next_alarm = next_high || next_low;
      end
   end

   // Alarm levels leave the block straight from flops
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         alarm_high <= 1'b0;
         alarm_low <= 1'b0;
         alarm_active <= 1'b0;
      end else begin
         alarm_high <= next_high;
         alarm_low <= next_low;
         alarm_active <= next_alarm;
      end
   end

   // Heartbeat; slow on purpose so it is visible
   int led_cnt;
   int next_led_cnt;
   logic next_led;

   // Free-running from reset, so a steady blink proves the clock runs
   always_comb begin
      next_led = led_green;
      if (led_cnt >= LED_HALF - 1) begin
         next_led_cnt = 0;
         next_led = !led_green;
      end else begin
         next_led_cnt = led_cnt + 1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         led_cnt <= 0;
         led_green <= 1'b0;
      end else begin
         led_cnt <= next_led_cnt;
         led_green <= next_led;
      end
   end
endmodule : tsma_top
`default_nettype wire

// *** shared/tsma_drive_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Duty request from the regulator to the output stage
interface tsma_drive_if import tsma_pkg::*;;
   logic signed [DUTY_W:0] duty;
   logic heat_polarity_b;
   modport ctrl (output duty, output heat_polarity_b);
   modport stage (input duty, input heat_polarity_b);
endinterface : tsma_drive_if
`default_nettype wire

// *** shared/tsma_pkg.sv ***
package tsma_pkg;
   // Data widths; temperatures are signed tenths of a degree
   localparam int TEMP_W = 16;
   localparam int DUTY_W = 10;
   localparam int ADC_W = 12;
   localparam int GAIN_W = 8;
   localparam logic [ADC_W-1:0] ADC_FULL = 12'hfff;

   // Fixed duty span: 511 steps each way, value in slots of the 511-slot frame
   localparam int DUTY_STEPS = 511;
   localparam logic signed [DUTY_W:0] DUTY_MAX = 11'sh1ff;

   // Alarm hysteresis span in tenths: 0.1 to 100 degrees
   localparam int HYST_MIN = 1;
   localparam int HYST_MAX = 1000;

   // Loop arithmetic
   localparam int PID_SHIFT = 4;
   localparam int INTEG_LIMIT = 32767;

   // Timing, from the 250 MHz reference clock
   localparam int CLK_KHZ = 250_000;
   localparam int LED_HALF_MS = 500;
   localparam int LED_HALF_CYCLES = LED_HALF_MS * CLK_KHZ;
   localparam int PID_TICK_US = 1000;
   localparam int PID_TICK_CYCLES = PID_TICK_US * CLK_KHZ / 1000;

   typedef enum logic [2:0] {
      host_value_setpoint_source,
      pot_setpoint_source,
      voltage_setpoint_source,
      current_loop_setpoint_source,
      differential_setpoint_source,
      keypad_setpoint_source
   } tsma_src_t;

   typedef enum logic [1:0] {
      on_off_regulation,
      pid_regulation,
      host_output_regulation
   } tsma_reg_t;

   typedef enum logic [1:0] {
      alarm_disabled,
      relative_alarm_mode,
      absolute_alarm_mode,
      host_forced_alarm
   } tsma_alarm_t;
endpackage : tsma_pkg

// *** verif/tsma_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host configuration software: mode settings land together on a send
module tsma_host_model import tsma_pkg::*; (
   input wire logic ref_clk,
   output var tsma_src_t setpoint_source,
   output var tsma_reg_t regulation,
   output var tsma_alarm_t alarm_type,
   output var logic heat_polarity_b,
   output var logic display_enable,
   output var logic host_alarm_cmd
);
   // Limits held by the keypad accessory; only an explicit push changes them
   logic signed [TEMP_W-1:0] keypad_low;
   logic signed [TEMP_W-1:0] keypad_high;

   // Safe idle settings until the first send
   initial begin
      keypad_low = '0;
      keypad_high = '0;
      setpoint_source = host_value_setpoint_source;
      regulation = on_off_regulation;
      alarm_type = alarm_disabled;
      heat_polarity_b = 1'b0;
      display_enable = 1'b0;
      host_alarm_cmd = 1'b0;
   end

   // Range push to the keypad; the configured range alone never reaches it
   task push_range_to_keypad(input logic signed [TEMP_W-1:0] lo, hi);
      keypad_low = lo;
      keypad_high = hi;
   endtask : push_range_to_keypad

   // A keypad entry is held inside the last pushed range
   function automatic logic signed [TEMP_W-1:0] keypad_entry(input logic signed [TEMP_W-1:0] v);
      return (v > keypad_high) ? keypad_high : (v < keypad_low) ? keypad_low : v;
   endfunction : keypad_entry

   task send(input tsma_src_t s, input tsma_reg_t r, input tsma_alarm_t a, input logic p, d, c);
      @(posedge ref_clk);
      setpoint_source <= s;
      regulation <= r;
      alarm_type <= a;
      heat_polarity_b <= p;
      display_enable <= d;
      host_alarm_cmd <= c;
   endtask : send
endmodule : tsma_host_model
`default_nettype wire

// *** verif/tsma_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsma_top_asserts import tsma_pkg::*; (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire tsma_src_t setpoint_source,
   input wire tsma_reg_t regulation,
   input wire tsma_alarm_t alarm_type,
   input wire logic display_enable,
   input wire logic host_alarm_cmd,
   input wire logic alarm_high_en,
   input wire logic signed [TEMP_W-1:0] host_setpoint,
   input wire logic signed [TEMP_W-1:0] fixed_set,
   input wire logic signed [TEMP_W-1:0] range_low,
   input wire logic signed [TEMP_W-1:0] range_high,
   input wire logic signed [TEMP_W-1:0] measured_temp,
   input wire logic signed [TEMP_W-1:0] alarm_high_set,
   input wire logic signed [TEMP_W-1:0] target_temp,
   input wire logic signed [DUTY_W:0] duty_level,
   input wire logic alarm_active,
   input wire logic alarm_high,
   input wire logic alarm_low,
   input wire logic term_a_pos,
   input wire logic term_b_pos
);
   // One clock domain, quiet while reset is low
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_host_target: assert property (setpoint_source == host_value_setpoint_source &&
      host_setpoint >= range_low && host_setpoint <= range_high |=> target_temp == $past(host_setpoint))
      else $error("target differs from host value");
   a_target_clamp: assert property (setpoint_source != keypad_setpoint_source && range_low <= range_high
      |=> target_temp >= $past(range_low) && target_temp <= $past(range_high))
      else $error("target outside range");
   a_keypad_hold: assert property (setpoint_source == keypad_setpoint_source && !display_enable
      |=> $stable(target_temp)) else $error("target moved without display enable");
   a_onoff_duty: assert property (regulation == on_off_regulation |=> duty_level ==
      ($past(target_temp) > $past(measured_temp) ? DUTY_MAX :
      $past(target_temp) < $past(measured_temp) ? -DUTY_MAX : 11'sh000)) else $error("on off duty wrong");
   a_fixed_duty: assert property (regulation == host_output_regulation &&
      setpoint_source == host_value_setpoint_source && fixed_set >= -16'sh01ff && fixed_set <= 16'sh01ff
      |=> duty_level == $past(fixed_set[DUTY_W:0])) else $error("fixed duty wrong");
   a_high_sets: assert property (alarm_type == absolute_alarm_mode && alarm_high_en &&
      measured_temp > alarm_high_set |=> alarm_high && alarm_active) else $error("high alarm missed");
   a_disabled_quiet: assert property (alarm_type == alarm_disabled
      |=> !alarm_active && !alarm_high && !alarm_low) else $error("alarm while disabled");
   a_forced_alarm: assert property (alarm_type == host_forced_alarm
      |=> alarm_active == $past(host_alarm_cmd) && !alarm_high) else $error("forced alarm wrong");
   a_terms_apart: assert property (!(term_a_pos && term_b_pos))
      else $error("both terminals positive");
endmodule : tsma_top_asserts
`default_nettype wire

// *** verif/tsma_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module tsma_top_test import tsma_pkg::*;;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   tsma_src_t setpoint_source;
   tsma_reg_t regulation;
   tsma_alarm_t alarm_type;
   logic heat_polarity_b, display_enable, host_alarm_cmd, alarm_high_en, alarm_low_en;
   logic signed [TEMP_W-1:0] host_setpoint, fixed_set, range_low, range_high, secondary_temp;
   logic signed [TEMP_W-1:0] keypad_setpoint, measured_temp, alarm_high_set, alarm_low_set, target_temp;
   logic [TEMP_W-1:0] alarm_hysteresis;
   logic [ADC_W-1:0] remote_code;
   logic [GAIN_W-1:0] gain_p, gain_i, gain_d;
   logic signed [DUTY_W:0] duty_level;
   logic alarm_active, alarm_high, alarm_low, led_green, term_a_pos, term_b_pos;
   int n_mismatch = 0;
   int samples_checked = 0;

   tsma_host_model host (.*);
   // Short blink and loop tick keep the run brief
   tsma_top #(.LED_HALF(8), .PID_TICK(4)) i_tsma_top (.*);

   always #2 ref_clk = ~ref_clk;

   task chk(input logic [TEMP_W-1:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Lets outputs settle; the longest register chain, input to terminal, is three cycles
   task wt;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : wt

   task t_setpoint;
      @(posedge ref_clk);
      range_low <= -16'sh00c8;
      range_high <= 16'sh03e8;
      host_setpoint <= 16'sh00fa;
      wt;
      chk(target_temp, 16'h00fa);
      @(posedge ref_clk);
      host_setpoint <= 16'sh05dc;
      wt;
      chk(target_temp, 16'h03e8);
      for (int s = 1; s < 4; s++) begin
         host.send(tsma_src_t'(s), on_off_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
         remote_code <= 12'hfff;
         wt;
         chk(target_temp, 16'h03e8);
      end
      @(posedge ref_clk);
      remote_code <= 12'h800;
      wt;
      chk(target_temp, 16'h0190);
      host.send(differential_setpoint_source, on_off_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
      secondary_temp <= 16'sh00c8;
      fixed_set <= 16'sh0032;
      host.push_range_to_keypad(range_low, range_high);
      keypad_setpoint <= host.keypad_entry(16'sh0064);
      wt;
      chk(target_temp, 16'h00fa);
      host.send(keypad_setpoint_source, on_off_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
      wt;
      chk(target_temp, 16'h00fa);
      host.send(keypad_setpoint_source, on_off_regulation, alarm_disabled, 1'b0, 1'b1, 1'b0);
      wt;
      chk(target_temp, 16'h0064);
   endtask : t_setpoint

   task t_regulation;
      host.send(host_value_setpoint_source, on_off_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
      host_setpoint <= 16'sh00fa;
      measured_temp <= 16'sh0064;
      wt;
      chk(duty_level, 16'h01ff);
      @(posedge ref_clk);
      measured_temp <= 16'sh0190;
      wt;
      chk(duty_level, -16'sh01ff);
      host.send(host_value_setpoint_source, host_output_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
      fixed_set <= -16'sh01ff;
      wt;
      chk(duty_level, -16'sh01ff);
      @(posedge ref_clk);
      fixed_set <= 16'sh01ff;
      wt;
      chk(duty_level, 16'h01ff);
      chk({term_a_pos, term_b_pos}, 16'h0002);
      host.send(host_value_setpoint_source, host_output_regulation, alarm_disabled, 1'b1, 1'b0, 1'b0);
      wt;
      chk({term_a_pos, term_b_pos}, 16'h0001);
      host.send(host_value_setpoint_source, pid_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
      measured_temp <= 16'sh0064;
      gain_p <= 8'h10;
      repeat (3) wt;
      chk(duty_level, 16'h0096);
      // Remote input sets the fixed duty: -200 + 1200 * 2048 / 4095 = 400
      host.send(voltage_setpoint_source, host_output_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
      wt;
      chk(duty_level, 16'h0190);
   endtask : t_regulation

   task t_alarm;
      host.send(host_value_setpoint_source, on_off_regulation, absolute_alarm_mode, 1'b0, 1'b0, 1'b0);
      alarm_high_set <= 16'sh012c;
      alarm_low_set <= 16'sh0064;
      alarm_high_en <= 1'b1;
      alarm_hysteresis <= 16'h0014;
      measured_temp <= 16'sh015e;
      wt;
      chk({alarm_active, alarm_high}, 16'h0003);
      @(posedge ref_clk);
      measured_temp <= 16'sh011d;
      wt;
      chk(alarm_high, 16'h0001);
      @(posedge ref_clk);
      measured_temp <= 16'sh0118;
      wt;
      chk(alarm_high, 16'h0000);
      @(posedge ref_clk);
      alarm_low_en <= 1'b1;
      measured_temp <= 16'sh0032;
      wt;
      chk({alarm_active, alarm_low}, 16'h0003);
      host.send(host_value_setpoint_source, on_off_regulation, alarm_disabled, 1'b0, 1'b0, 1'b0);
      wt;
      chk(alarm_active, 16'h0000);
      host.send(host_value_setpoint_source, on_off_regulation, relative_alarm_mode, 1'b0, 1'b0, 1'b0);
      alarm_low_en <= 1'b0;
      alarm_high_set <= 16'sh0032;
      measured_temp <= 16'sh0136;
      wt;
      chk(alarm_high, 16'h0001);
      @(posedge ref_clk);
      host_setpoint <= 16'sh012c;
      wt;
      chk(alarm_high, 16'h0000);
      host.send(host_value_setpoint_source, on_off_regulation, host_forced_alarm, 1'b0, 1'b0, 1'b1);
      wt;
      chk(alarm_active, 16'h0001);
   endtask : t_alarm

   // Cycles between two toggles of the green indicator
   task t_led;
      logic l;
      int n;
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         #1;
         l = led_green;
         n = 1;
         while (led_green === l && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
         end
      end
      chk(n, 16'h0008);
   endtask : t_led

   task finish_test;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Every input defined at time zero, then reset and the scenarios
   initial begin
      {alarm_high_en, alarm_low_en, remote_code, gain_p, gain_i, gain_d} = '0;
      {host_setpoint, fixed_set, range_low, range_high, secondary_temp, keypad_setpoint} = '0;
      {measured_temp, alarm_high_set, alarm_low_set, alarm_hysteresis} = '0;
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      t_setpoint;
      t_regulation;
      t_alarm;
      t_led;
      finish_test;
   end

   // Hang guard, far beyond the under two hundred cycles the scenarios need
   initial begin
      #20000;
      n_mismatch++;
      finish_test;
   end
endmodule : tsma_top_test

bind tsma_top tsma_top_asserts i_tsma_top_asserts (.*);
`default_nettype wire
